// *** core/tmcd_pkg.sv ***
// Constants, types and the register map of the test-mode command decoder
package tmcd_pkg;
	// ****************************************
	// Message type octets
	// ****************************************
	localparam logic [7:0] MT_ACT_CMD = 8'h0C;
	localparam logic [7:0] MT_ACT_ACK = 8'h0D;
	localparam logic [7:0] MT_DEACT = 8'h10;
	localparam logic [7:0] MT_TEST_IF = 8'h14;
	localparam logic [7:0] MT_PKT_CMD = 8'h24;
	// ****************************************
	// Field layouts
	// ****************************************
	localparam logic [2:0] DEV_NORMAL = 3'h0;
	localparam logic [2:0] DEV_DL_DECODER = 3'h1;
	localparam logic [2:0] DEV_UL_ENCODER = 3'h2;
	localparam logic [2:0] DEV_ACOUSTIC = 3'h4;
	localparam int DEV_SPARE_HI = 7;
	localparam int DEV_SPARE_LO = 3;
	localparam int PDU_LMODE_BIT = 7;
	localparam int PDU_COUNT_HI_MSB = 3;
	localparam int MODE_FLAG_BIT = 0;
	localparam int MODE_TS_MSB = 3;
	localparam int MODE_TS_LSB = 1;
	localparam logic [10:0] PDU_LEN_MIN = 11'h08C;
	localparam logic [10:0] PDU_LEN_MAX = 11'h618;
	localparam logic [8:0] PRBS_SEED = 9'h1FF;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_PDU_LEN = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_PDU_CFG = 8'h0C;
	localparam logic CTRL_EN_RESET = 1'b1;
	localparam logic [10:0] PDU_LEN_RESET = 11'h08C;
	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {ST_IDLE, ST_TESTDEV, ST_PDU_HI, ST_PDU_LO, ST_MODE} tmcd_state_t;
	typedef struct packed {
		logic [11:0] count;
		logic unlimited;
		logic loopback;
		logic [2:0] timeslot;
	} tmcd_pkt_cfg_t;
	localparam tmcd_pkt_cfg_t PKT_CFG_RESET = '0;
endpackage : tmcd_pkg

// *** core/tmcd_top.sv ***
// Test-mode command decoder with test PDU source and APB registers
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module tmcd_top
	import tmcd_pkg::*;
#(
	parameter bit GEN_SUPPORTED = 1'b1,
	parameter bit LOOP_SUPPORTED = 1'b1,
	parameter bit ZERO_UNLIMITED = 1'b1,
	parameter logic [10:0] MAX_PDU_LEN = PDU_LEN_MAX
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_valid,
	input wire logic rx_first,
	input wire logic [7:0] rx_data,
	output logic tx_valid,
	output logic [7:0] tx_data,
	input wire logic tx_ready,
	output logic test_if_active,
	output logic [2:0] tested_device,
	output logic loopback_sel,
	output logic [2:0] timeslot_index,
	output logic pdu_valid,
	output logic [7:0] pdu_data,
	output logic pdu_last,
	input wire logic pdu_ready
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ****************************************
	// APB registers
	// ****************************************
	logic ctrl_en;
	logic next_ctrl_en;
	logic [10:0] pdu_len;
	logic [10:0] next_pdu_len;
	logic [31:0] next_prdata;
	logic apb_hit;
	logic [10:0] eff_len;
	tmcd_state_t state;
	tmcd_state_t next_state;
	tmcd_pkt_cfg_t cfg;
	tmcd_pkt_cfg_t next_cfg;
	logic [7:0] pdu_hi;
	logic [7:0] next_pdu_hi;
	logic [7:0] pdu_lo;
	logic [7:0] next_pdu_lo;
	logic [7:0] ign_cnt;
	logic [7:0] next_ign_cnt;
	logic gen_run;
	logic [11:0] pdus_left;
	logic [10:0] octets_left;

	always_comb
	begin
		apb_hit = (paddr == REG_CTRL) || (paddr == REG_PDU_LEN) ||
			(paddr == REG_STATUS) || (paddr == REG_PDU_CFG);
		pready = 1'b1;
		pslverr = psel && penable && !apb_hit;
		next_ctrl_en = ctrl_en;
		next_pdu_len = pdu_len;
		next_prdata = prdata;
		if (psel && penable && pwrite && paddr == REG_CTRL)
			next_ctrl_en = pwdata[0];
		if (psel && penable && pwrite && paddr == REG_PDU_LEN)
			next_pdu_len = pwdata[10:0];
		// Read data is latched in setup so the access phase answers at once
		if (psel && !penable && !pwrite)
		begin
			unique case (paddr)
				REG_CTRL: next_prdata = {31'h0, ctrl_en};
				REG_PDU_LEN: next_prdata = {21'h0, pdu_len};
				REG_STATUS: next_prdata = {8'h0, ign_cnt, 6'h00, cfg.unlimited, gen_run,
					cfg.timeslot, cfg.loopback, tested_device, test_if_active};
				REG_PDU_CFG: next_prdata = {4'h0, pdus_left, 4'h0, cfg.count};
				default: next_prdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_en <= CTRL_EN_RESET;
			pdu_len <= PDU_LEN_RESET;
			prdata <= 32'h0;
		end
		else
		begin
			ctrl_en <= next_ctrl_en;
			pdu_len <= next_pdu_len;
			prdata <= next_prdata;
		end
	end

	assign eff_len = (pdu_len < PDU_LEN_MIN) ? PDU_LEN_MIN :
		(pdu_len > MAX_PDU_LEN) ? MAX_PDU_LEN : pdu_len;

	// ****************************************
	// Message decoder
	// ****************************************
	logic ack_pend;
	logic next_ack_pend;
	logic next_active;
	logic [2:0] next_device;
	logic [7:0] next_tx_data;
	logic start;
	logic dev_legal;
	logic mode_ok;
	logic [11:0] rx_count;

	always_comb
	begin
		next_state = state;
		next_active = test_if_active;
		next_device = tested_device;
		next_cfg = cfg;
		next_pdu_hi = pdu_hi;
		next_pdu_lo = pdu_lo;
		next_ack_pend = ack_pend;
		next_tx_data = tx_data;
		next_ign_cnt = ign_cnt;
		start = 1'b0;
		dev_legal = (rx_data[2:0] == DEV_NORMAL) || (rx_data[2:0] == DEV_DL_DECODER) ||
			(rx_data[2:0] == DEV_UL_ENCODER) || (rx_data[2:0] == DEV_ACOUSTIC);
		rx_count = {pdu_hi[PDU_COUNT_HI_MSB:0], pdu_lo};
		// Zero count only when unlimited is built
		mode_ok = pdu_hi[PDU_LMODE_BIT] && (rx_count != 12'h000 || ZERO_UNLIMITED);
		if (tx_valid && tx_ready)
			next_ack_pend = 1'b0;
		// Interface support switched off by software
		if (!ctrl_en)
			next_state = ST_IDLE;
		else if (rx_valid && rx_first)
		begin
			next_state = ST_IDLE;
			case (rx_data)
				MT_ACT_CMD:
				begin
					next_active = 1'b1;
					next_ack_pend = 1'b1;
					next_tx_data = MT_ACT_ACK;
				end
				MT_DEACT:
				begin
					next_active = 1'b0;
					next_ack_pend = 1'b0;
				end
				MT_TEST_IF: next_state = ST_TESTDEV;
				MT_PKT_CMD: next_state = ST_PDU_HI;
				default: next_ign_cnt = 8'(ign_cnt + 8'h01);
			endcase
		end
		else if (rx_valid)
		begin
			unique case (state)
				ST_IDLE: next_state = ST_IDLE;
				ST_TESTDEV:
				begin
					next_state = ST_IDLE;
					if (dev_legal)
						next_device = rx_data[2:0];
					else
						next_ign_cnt = 8'(ign_cnt + 8'h01);
				end
				ST_PDU_HI:
				begin
					next_pdu_hi = rx_data;
					next_state = ST_PDU_LO;
				end
				ST_PDU_LO:
				begin
					next_pdu_lo = rx_data;
					next_state = ST_MODE;
				end
				ST_MODE:
				begin
					next_state = ST_IDLE;
					if (mode_ok)
					begin
						start = 1'b1;
						next_cfg.count = rx_count;
						next_cfg.unlimited = (rx_count == 12'h000);
						// Mode bit only when both sources exist
						next_cfg.loopback = (GEN_SUPPORTED && LOOP_SUPPORTED) ?
							rx_data[MODE_FLAG_BIT] : !GEN_SUPPORTED;
						next_cfg.timeslot = rx_data[MODE_TS_MSB:MODE_TS_LSB];
					end
					else
						next_ign_cnt = 8'(ign_cnt + 8'h01);
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= ST_IDLE;
			test_if_active <= 1'b0;
			tested_device <= DEV_NORMAL;
			cfg <= PKT_CFG_RESET;
			pdu_hi <= 8'h00;
			pdu_lo <= 8'h00;
			ack_pend <= 1'b0;
			tx_data <= 8'h00;
			ign_cnt <= 8'h00;
		end
		else
		begin
			state <= next_state;
			test_if_active <= next_active;
			tested_device <= next_device;
			cfg <= next_cfg;
			pdu_hi <= next_pdu_hi;
			pdu_lo <= next_pdu_lo;
			ack_pend <= next_ack_pend;
			tx_data <= next_tx_data;
			ign_cnt <= next_ign_cnt;
		end
	end

	// No answer while a message is still arriving
	assign tx_valid = ack_pend && state == ST_IDLE;
	assign loopback_sel = cfg.loopback;
	assign timeslot_index = cfg.timeslot;

	act_ack_code_a: assert property (tx_valid |-> tx_data == MT_ACT_ACK)
		else $error("acknowledgement carries wrong type");
	act_answer_a: assert property (
		(ctrl_en && rx_valid && rx_first && rx_data == MT_ACT_CMD) |=>
		test_if_active && ack_pend && tx_valid)
		else $error("activation not answered");
	deact_clear_a: assert property (
		(ctrl_en && rx_valid && rx_first && rx_data == MT_DEACT) |=> !test_if_active && !tx_valid)
		else $error("deactivation not honoured");
	sequence s_testdev_octet;
		ctrl_en && state == ST_TESTDEV && rx_valid && !rx_first;
	endsequence
	testdev_take_a: assert property (
		s_testdev_octet ##0 dev_legal |=> tested_device == $past(rx_data[2:0]))
		else $error("tested device not taken");
	reserved_keep_a: assert property (
		s_testdev_octet ##0 !dev_legal |=> $stable(tested_device))
		else $error("reserved selector changed setting");
	half_duplex_a: assert property (tx_valid |-> state == ST_IDLE)
		else $error("answer sent while receiving");
	timeslot_take_a: assert property (
		start |=> timeslot_index == $past(rx_data[MODE_TS_MSB:MODE_TS_LSB]))
		else $error("timeslot offset not taken");
	lmode_reserved_a: assert property (
		(state == ST_MODE && rx_valid && !rx_first && !pdu_hi[PDU_LMODE_BIT]) |-> !start)
		else $error("reserved length mode started a test");

	// ****************************************
	// Test PDU source
	// ****************************************
	logic next_gen_run;
	logic [11:0] next_pdus_left;
	logic [10:0] next_octets_left;
	logic [8:0] prbs;
	logic [8:0] next_prbs;

	function automatic logic [8:0] tmcd_prbs_step8(input logic [8:0] s);
		logic [8:0] r;
		r = s;
		for (int i = 0; i < 8; i++)
			r = {r[7:0], r[8] ^ r[4]};
		return r;
	endfunction : tmcd_prbs_step8

	always_comb
	begin
		next_gen_run = gen_run;
		next_pdus_left = pdus_left;
		next_octets_left = octets_left;
		next_prbs = prbs;
		if (start)
		begin
			next_gen_run = !next_cfg.loopback;
			next_pdus_left = next_cfg.count;
			next_octets_left = 11'(eff_len - 11'h001);
			// Each command restarts the sequence from its seed
			next_prbs = PRBS_SEED;
		end
		else if (pdu_valid && pdu_ready)
		begin
			next_prbs = tmcd_prbs_step8(prbs);
			if (octets_left == 11'h000)
			begin
				next_octets_left = 11'(eff_len - 11'h001);
				if (!cfg.unlimited)
				begin
					next_pdus_left = 12'(pdus_left - 12'h001);
					if (pdus_left == 12'h001)
						next_gen_run = 1'b0;
				end
			end
			else
				next_octets_left = 11'(octets_left - 11'h001);
		end
		// Disable stops the source, a taken octet still advances
		if (!ctrl_en)
			next_gen_run = 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			gen_run <= 1'b0;
			pdus_left <= 12'h000;
			octets_left <= 11'h000;
			prbs <= PRBS_SEED;
		end
		else
		begin
			gen_run <= next_gen_run;
			pdus_left <= next_pdus_left;
			octets_left <= next_octets_left;
			prbs <= next_prbs;
		end
	end

	assign pdu_valid = gen_run;
	assign pdu_last = gen_run && octets_left == 11'h000;
	assign pdu_data = prbs[7:0];

	sequence s_pdu_end;
		pdu_valid && pdu_ready && pdu_last && !cfg.unlimited && pdus_left == 12'h001 && !start;
	endsequence
	pdu_len_a: assert property (
		start |=> octets_left == 11'(eff_len - 11'h001) && eff_len >= PDU_LEN_MIN &&
		eff_len <= MAX_PDU_LEN)
		else $error("PDU length out of range");
	pdu_count_a: assert property (
		start |=> pdus_left == $past(rx_count))
		else $error("PDU count not taken");
	pdu_stop_a: assert property ((ctrl_en and s_pdu_end) |=> !pdu_valid)
		else $error("source ran past the count");
	prbs_only_a: assert property (
		pdu_valid && pdu_ready && !start |=> pdu_data == 8'(tmcd_prbs_step8($past(prbs))))
		else $error("payload departed from sequence");
	loop_idle_a: assert property (start && next_cfg.loopback |=> !pdu_valid)
		else $error("generator ran in loopback");
endmodule : tmcd_top
`default_nettype wire

// *** tb/tmcd_sim_model.sv ***
// Simulator-side partner: sends test messages, takes answers and test PDUs
`timescale 1ns/1ps
`default_nettype none
module tmcd_sim_model
	import tmcd_pkg::*;
#(
	parameter int SUP_CYCLES = 2000
)(
	input wire logic pclk,
	input wire logic slow,
	output logic rx_valid,
	output logic rx_first,
	output logic [7:0] rx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic pdu_valid,
	output logic pdu_ready,
	output logic sup_expired
);
	logic [3:0] pace = 4'h0;
	int sup_cnt = -1;
	initial
	begin
		rx_valid = 1'b0;
		rx_first = 1'b0;
		rx_data = 8'hA5;
		tx_ready = 1'b0;
		pdu_ready = 1'b0;
		sup_expired = 1'b0;
	end
	always @(posedge pclk)
	begin
		pace <= pace + 4'h1;
		tx_ready <= !rx_valid && (!slow || pace[1:0] == 2'h3);
		pdu_ready <= !slow || pace[1:0] == 2'h1;
	end
	// supervision timer; no loop-close command is sent here, so only arms it
	always @(posedge pclk)
	begin
		if (pdu_valid === 1'b1)
			sup_cnt <= -1;
		else if (sup_cnt >= 0)
			sup_cnt <= sup_cnt + 1;
		if (sup_cnt > SUP_CYCLES)
			sup_expired <= 1'b1;
	end
	task automatic send_msg(input logic [7:0] msg [$], input logic gaps);
		for (int i = 0; i < msg.size(); i++)
		begin
			@(posedge pclk);
			rx_valid <= 1'b1;
			rx_first <= (i == 0);
			rx_data <= msg[i];
			if (gaps)
			begin
				@(posedge pclk);
				rx_valid <= 1'b0;
				rx_data <= ~msg[i];
			end
		end
		if (msg.size() == 4 && msg[0] == MT_PKT_CMD && !msg[3][0])
			sup_cnt <= 0;
		@(posedge pclk);
		rx_valid <= 1'b0;
		rx_data <= ~rx_data;
	endtask : send_msg
endmodule : tmcd_sim_model
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the test-mode command decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import tmcd_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, pready, pslverr, slow, chk, free_run, sup_expired;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdv, r;
	logic rx_valid, rx_first, tx_valid, tx_ready, test_if_active, loopback_sel;
	logic [7:0] rx_data, tx_data, pdu_data;
	logic [2:0] tested_device, timeslot_index, dev, ts;
	logic pdu_valid, pdu_last, pdu_ready, erv, act, lb;
	logic [7:0] m [$];
	logic [31:0] q_cfg [$];
	logic [7:0] q_tx [$];
	logic [8:0] q_pdu [$];
	logic [31:0] seed = 32'h0A623730;
	int n_fail = 0;
	int total_checks = 0;
	int cyc = 0;
	logic [7:0] ign = 8'h00;
	always #2 pclk = ~pclk;
	tmcd_top i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_first(rx_first),
		.rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
		.test_if_active(test_if_active), .tested_device(tested_device),
		.loopback_sel(loopback_sel), .timeslot_index(timeslot_index),
		.pdu_valid(pdu_valid), .pdu_data(pdu_data), .pdu_last(pdu_last),
		.pdu_ready(pdu_ready));
	tmcd_sim_model i_sim (.pclk(pclk), .slow(slow), .rx_valid(rx_valid),
		.rx_first(rx_first), .rx_data(rx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .pdu_valid(pdu_valid), .pdu_ready(pdu_ready),
		.sup_expired(sup_expired));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rdv = prdata;
		erv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Note the expected configuration, then let the watcher sample it
	task automatic cfg();
		q_cfg.push_back({24'h0, act, dev, lb, ts});
		@(posedge pclk);
		chk <= 1'b1;
		@(posedge pclk);
		chk <= 1'b0;
	endtask : cfg
	// Stream continues across PDUs; restarts from the seed per command
	task automatic note_pdus(input int len, input int cnt);
		logic [8:0] s;
		s = PRBS_SEED;
		for (int n = 0; n < len * cnt; n++)
		begin
			q_pdu.push_back({(n % len) == len - 1, s[7:0]});
			repeat (8)
				s = {s[7:0], s[8] ^ s[4]};
		end
	endtask : note_pdus
	task automatic pkt(input logic [11:0] c, input logic l, input logic mb);
		logic [2:0] t;
		r = rnd();
		t = r[2:0];
		m = '{MT_PKT_CMD, {l, 3'h0, c[11:8]}, c[7:0], {4'h0, t, mb}};
		i_sim.send_msg(m, r[3]);
		if (l)
		begin
			ts = t;
			lb = mb;
		end
		else
			ign++;
		cfg();
	endtask : pkt
	always @(posedge pclk)
	begin
		if (chk)
			check("config", {24'h0, test_if_active, tested_device, loopback_sel,
				timeslot_index}, q_cfg.pop_front());
		if (tx_valid === 1'b1 && tx_ready)
			check("answer", {24'h0, tx_data}, {24'h0, q_tx.pop_front()});
		if (pdu_valid === 1'b1 && pdu_ready && !free_run)
			check("pdu", {23'h0, pdu_last, pdu_data}, {23'h0, q_pdu.pop_front()});
	end
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			n_fail++;
			print_verdict();
		end
	end
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata, slow, chk, free_run} = '0;
		{act, dev, lb, ts} = '0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, REG_CTRL, 32'h0);
		check("ctrl", rdv, 32'h1);
		apb(1'b0, REG_PDU_LEN, 32'h0);
		check("len", rdv, 32'h8C);
		$display("test reset done");
		slow <= 1'b1;
		act = 1'b1;
		q_tx.push_back(MT_ACT_ACK);
		m = '{MT_ACT_CMD};
		i_sim.send_msg(m, 1'b0);
		cfg();
		while (q_tx.size() != 0)
			@(posedge pclk);
		$display("test activation done");
		for (int d = 0; d < 8; d++)
		begin
			m = '{MT_TEST_IF, 8'(d)};
			i_sim.send_msg(m, d[0]);
			if (d == 0 || d == 1 || d == 2 || d == 4)
				dev = 3'(d);
			else
				ign++;
			cfg();
		end
		m = '{8'h55};
		i_sim.send_msg(m, 1'b0);
		ign++;
		cfg();
		$display("test selector done");
		apb(1'b1, REG_PDU_LEN, 32'd100);
		note_pdus(140, 2);
		pkt(12'h002, 1'b1, 1'b0);
		while (q_pdu.size() != 0)
			@(posedge pclk);
		repeat (2) @(posedge pclk);
		check("stream end", {31'h0, pdu_valid}, 32'h0);
		pkt(12'h001, 1'b1, 1'b1);
		pkt(12'h003, 1'b0, 1'b0);
		$display("test packet done");
		free_run <= 1'b1;
		pkt(12'h000, 1'b1, 1'b0);
		apb(1'b0, REG_STATUS, 32'h0);
		check("status", {rdv[23:16], rdv[9:8], rdv[0]}, {ign, 3'h7});
		apb(1'b1, REG_CTRL, 32'h0);
		repeat (2) @(posedge pclk);
		check("stopped", {31'h0, pdu_valid}, 32'h0);
		free_run <= 1'b0;
		apb(1'b1, REG_CTRL, 32'h1);
		apb(1'b0, 8'h10, 32'h0);
		check("unmapped", {erv, rdv[30:0]}, 32'h80000000);
		$display("test registers done");
		act = 1'b0;
		m = '{MT_DEACT};
		i_sim.send_msg(m, 1'b0);
		cfg();
		repeat (4) @(posedge pclk);
		check("timer", {31'h0, sup_expired}, 32'h0);
		$display("test deactivation done");
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire
